/* File: verif/staged_watchdog_reset_unit_checker.sv */
// Purpose: Port-level assertions of the watchdog unit
// Assumes: Bound to the top module, one clock domain
// Notes: Reset hold length is counted on the second core output
`default_nettype none

module staged_watchdog_reset_unit_checker (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic IRQ_O,
	input wire logic FIRST_PROCESSOR_CORE_RST_O,
	input wire logic SECOND_PROCESSOR_CORE_RST_O,
	input wire logic SECURE_REGS_RST_O,
	input wire logic DIGITAL_CORE_RST_O,
	input wire logic SYSTEM_RST_O
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========
	// Helpers
	wire logic bad = (PADDR_I[1:0] != 2'h0) || (PADDR_I[7:5] > 3'h3) ||
		(PADDR_I[7:5] == 3'h0 && PADDR_I[4]);
	logic [5:0] run;

	// Saturates so a long re-triggered hold cannot wrap
	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			run <= 6'h00;
		else
			run <= SECOND_PROCESSOR_CORE_RST_O ? run + {5'h00, run != 6'h3f} : 6'h00;
	end

	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!NRST_I);

	// ==========
	// Properties
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_bad_read;
		s_setup ##0 (!PWRITE_I && bad);
	endsequence
	property p_reset_quiet;
		disable iff (1'h0) !NRST_I |-> !(PREADY_O || IRQ_O || DIGITAL_CORE_RST_O || SYSTEM_RST_O);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("output active in reset");
	property p_ready;
		$rose(NRST_I) |-> ##3 PREADY_O;
	endproperty
	a_ready: assert property (p_ready) else $error("ready late after reset");
	property p_pslverr;
		s_setup |=> PSLVERR_O == bad;
	endproperty
	a_pslverr: assert property (p_pslverr) else $error("error flag wrong");
	property p_rdata;
		s_bad_read |=> PRDATA_O == 32'h0000_0000;
	endproperty
	a_rdata: assert property (p_rdata) else $error("unmapped read not zero");
	property p_secure;
		$rose(FIRST_PROCESSOR_CORE_RST_O) |-> SECURE_REGS_RST_O;
	endproperty
	a_secure: assert property (p_secure) else $error("secure reset missing");
	property p_digital;
		DIGITAL_CORE_RST_O |-> FIRST_PROCESSOR_CORE_RST_O && SECOND_PROCESSOR_CORE_RST_O;
	endproperty
	a_digital: assert property (p_digital) else $error("digital reset missed a core");
	property p_system;
		SYSTEM_RST_O |-> DIGITAL_CORE_RST_O;
	endproperty
	a_system: assert property (p_system) else $error("system reset too narrow");
	property p_hold;
		$fell(SECOND_PROCESSOR_CORE_RST_O) |-> run >= 6'h0f;
	endproperty
	a_hold: assert property (p_hold) else $error("core reset too short");
endmodule

`default_nettype wire

/* File: verif/staged_watchdog_reset_unit_tb_top.sv */
// Purpose: Self-checking bench of the staged watchdog unit
// Assumes: Boot timeouts shortened to 50 and 4; slow clock is CLK_I/16
// Notes: Bench drives every port itself
`include "wdt_defines.svh"
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
$display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end

module staged_watchdog_reset_unit_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ==========
	// Signals and unit
	logic clk = 1'h0;
	logic nrst, psel, penable, pwrite, slow, strap, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, rd;
	logic [3:0] sdiv = 4'h0;
	wire logic pready, pslverr;
	wire logic [31:0] prdata;
	// Bit 0 first core, 1 second, 2 secure, 3 digital, 4 system, 5 interrupt
	wire logic [5:0] mon;
	int fails = 0;
	int samples_checked = 0;
	int n;

	staged_watchdog_reset_unit #(
		.BOOT_TIMEOUT(32'h0000_0032),
		.BOOT_TIMEOUT_LP(32'h0000_0004)
	) dut (
		.CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .SLOW_CLK_I(slow), .FLASH_BOOT_I(strap), .IRQ_O(mon[5]),
		.FIRST_PROCESSOR_CORE_RST_O(mon[0]), .SECOND_PROCESSOR_CORE_RST_O(mon[1]),
		.SECURE_REGS_RST_O(mon[2]), .DIGITAL_CORE_RST_O(mon[3]), .SYSTEM_RST_O(mon[4])
	);

	always #12.5 clk = ~clk;

	always @(posedge clk)
	begin
		sdiv <= sdiv + 4'h1;
		slow <= sdiv[3];
	end

	// ==========
	// Bus and helpers
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0000_0000);
		`CHK(rd, e)
	endtask

	function automatic logic [7:0] wb(input int w, input logic [2:0] r);
		return 8'((w + 1) * 32 + int'(r) * 4);
	endfunction

	// Bounded wait; caller judges the bit afterwards
	task automatic wait_bit(input int b, input int lim);
		n = 0;
		while (mon[b] !== 1'h1 && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========
	// Scenarios
	task automatic t_regs;
		rchk(`OFS_PROTECT, 32'h0000_0001);
		rchk(wb(0, `IDX_TIMEOUT0), `TIMEOUT_RESET);
		rchk(wb(2, `IDX_TIMEOUT3), `TIMEOUT_RESET);
		apb(1'h1, 8'h10, 32'hffff_ffff);
		`CHK(err, 1'h1)
		rchk(8'h82, 32'h0000_0000);
		apb(1'h1, wb(0, `IDX_CONFIG), 32'h0000_0003);
		rchk(wb(0, `IDX_CONFIG), 32'h0000_0000);
		$display("regs done");
	endtask

	task automatic t_irq;
		apb(1'h1, `OFS_PROTECT, `WP_KEY);
		apb(1'h1, wb(1, `IDX_TIMEOUT0), 32'h0000_0005);
		apb(1'h1, `OFS_INT_MASK, 32'h0000_0002);
		apb(1'h1, wb(1, `IDX_CONFIG), 32'h0000_0003);
		wait_bit(5, 40);
		`CHK(mon[5], 1'h1)
		apb(1'h1, wb(1, `IDX_CONFIG), 32'h0000_0000);
		rchk(`OFS_INT_STATUS, 32'h0000_0002);
		apb(1'h1, `OFS_INT_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk);
		`CHK(mon[5], 1'h0)
		apb(1'h1, `OFS_INT_STATUS, 32'h0000_0002);
		apb(1'h1, `OFS_INT_MASK, 32'h0000_0002);
		repeat (2) @(posedge clk);
		`CHK(mon[5], 1'h0)
		$display("irq done");
	endtask

	// Stages 0 and 2 on, stage 1 off, stage 2 resets the second core
	task automatic t_stages;
		apb(1'h1, wb(0, `IDX_TIMEOUT0), 32'h0000_000a);
		apb(1'h1, wb(0, 3'h3), 32'h0000_000a);
		apb(1'h1, wb(0, `IDX_CONFIG), 32'h0000_220b);
		wait_bit(1, 60);
		`CHK(mon[4:0], 5'h02)
		`CHK(n >= 18, 1'h1)
		apb(1'h1, wb(0, `IDX_CONFIG), 32'h0000_0000);
		repeat (20) @(posedge clk);
		$display("stages done");
	endtask

	// Only stage 3 on, resetting the first core
	task automatic t_core;
		apb(1'h1, wb(0, `IDX_TIMEOUT3), 32'h0000_0003);
		apb(1'h1, wb(0, `IDX_CONFIG), 32'h0000_0811);
		wait_bit(0, 40);
		`CHK(mon[4:0], 5'h05)
		apb(1'h1, wb(0, `IDX_CONFIG), 32'h0000_0000);
		repeat (20) @(posedge clk);
		$display("core done");
	endtask

	task automatic t_feed;
		apb(1'h1, wb(0, `IDX_TIMEOUT0), 32'h0000_001e);
		apb(1'h1, wb(0, `IDX_CONFIG), 32'h0000_0043);
		repeat (8)
		begin
			repeat (8) @(posedge clk);
			apb(1'h1, wb(0, `IDX_FEED), 32'h0000_0000);
			`CHK(mon[3], 1'h0)
		end
		apb(1'h0, wb(0, `IDX_COUNT), 32'h0000_0000);
		`CHK(rd < 32'h0000_0008, 1'h1)
		wait_bit(3, 60);
		`CHK(mon[4:0], 5'h0f)
		apb(1'h1, wb(0, `IDX_CONFIG), 32'h0000_0000);
		repeat (20) @(posedge clk);
		$display("feed done");
	endtask

	// System action on a main watchdog stays digital; low-power one reaches all
	task automatic t_lp;
		apb(1'h1, wb(1, `IDX_TIMEOUT0), 32'h0000_0004);
		apb(1'h1, wb(1, `IDX_CONFIG), 32'h0000_0063);
		wait_bit(3, 40);
		`CHK(mon[4:3], 2'h1)
		apb(1'h1, wb(1, `IDX_CONFIG), 32'h0000_0000);
		apb(1'h1, wb(2, `IDX_TIMEOUT0), 32'h0000_0002);
		apb(1'h1, wb(2, `IDX_CONFIG), 32'h0000_0063);
		wait_bit(4, 100);
		`CHK(mon[4:0], 5'h1f)
		`CHK(n >= 10, 1'h1)
		apb(1'h1, wb(2, `IDX_CONFIG), 32'h0000_0000);
		repeat (20) @(posedge clk);
		$display("low-power done");
	endtask

	task automatic t_boot;
		nrst <= 1'h0;
		strap <= 1'h1;
		repeat (3) @(posedge clk);
		nrst <= 1'h1;
		repeat (8) @(posedge clk);
		rchk(`OFS_BOOT_CTRL, 32'h0000_0003);
		wait_bit(3, 80);
		`CHK(mon[3], 1'h1)
		`CHK(n >= 30, 1'h1)
		wait_bit(4, 80);
		`CHK(mon[4], 1'h1)
		$display("boot done");
	endtask

	initial
	begin
		nrst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		slow = 1'h0;
		strap = 1'h0;
		#2 nrst = 1'h0;
		repeat (20) @(posedge clk);
		nrst <= 1'h1;
		repeat (4) @(posedge clk);
		t_regs;
		t_irq;
		t_stages;
		t_core;
		t_feed;
		t_lp;
		t_boot;
		give_verdict;
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		#75000;
		fails++;
		give_verdict;
	end
endmodule

bind staged_watchdog_reset_unit staged_watchdog_reset_unit_checker u_check (
	.CLK_I(CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O),
	.FIRST_PROCESSOR_CORE_RST_O(FIRST_PROCESSOR_CORE_RST_O),
	.SECOND_PROCESSOR_CORE_RST_O(SECOND_PROCESSOR_CORE_RST_O),
	.SECURE_REGS_RST_O(SECURE_REGS_RST_O), .DIGITAL_CORE_RST_O(DIGITAL_CORE_RST_O),
	.SYSTEM_RST_O(SYSTEM_RST_O)
);

`default_nettype wire

/* File: verilog/bit_sync.sv */
// Purpose: Two flip-flop synchroniser
// Assumes: Asynchronous active-low reset
// Notes: First stage is read only by the second
`default_nettype none

module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta <= '0;
			q_o <= '0;
		end
		else
		begin
			meta <= d_i;
			q_o <= meta;
		end
	end

endmodule

`default_nettype wire

/* File: verilog/staged_watchdog_reset_unit.sv */
// Purpose: Three staged watchdogs with scoped reset requests, APB registers
// Assumes: One clock; slow low-power clock sampled as a pin
// Notes: Resets are requests to the chip's reset logic, held RST_HOLD cycles
//
// Decided for this implementation: the APB slave port and the register addresses.
`include "wdt_defines.svh"
`default_nettype none

module staged_watchdog_reset_unit
	import wdt_pkg::*;
#(
	parameter int NWDT = 3,
	parameter logic [31:0] BOOT_TIMEOUT = 32'h0100_0000,
	parameter logic [31:0] BOOT_TIMEOUT_LP = 32'h0001_0000
) (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic SLOW_CLK_I,
	input wire logic FLASH_BOOT_I,
	output logic IRQ_O,
	output logic FIRST_PROCESSOR_CORE_RST_O,
	output logic SECOND_PROCESSOR_CORE_RST_O,
	output logic SECURE_REGS_RST_O,
	output logic DIGITAL_CORE_RST_O,
	output logic SYSTEM_RST_O
);

	localparam int LP = NWDT - 1;

	// ==========================================================
	// Reset release and pin synchronisers
	logic rst_n;
	logic slow_s;
	logic strap_s;
	logic slow_q;
	logic slow_tick;

	bit_sync #(.WIDTH(1)) u_rst_sync
	(
		.clk_i(CLK_I),
		.rst_n_i(NRST_I),
		.d_i(1'b1),
		.q_o(rst_n)
	);

	bit_sync #(.WIDTH(2)) u_pin_sync
	(
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.d_i({SLOW_CLK_I, FLASH_BOOT_I}),
		.q_o({slow_s, strap_s})
	);

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			slow_q <= 1'b0;
		else
			slow_q <= slow_s;
	end

	// Slow clock rising edge; it must run below a third of CLK_I
	assign slow_tick = slow_s & ~slow_q;

	// ==========================================================
	// APB decode
	logic wr;
	logic setup;
	logic [2:0] sel;
	logic [2:0] idx;
	logic [1:0] wsel;
	logic is_global;
	logic is_wdt;
	logic unmapped;
	logic cfg_wr;

	assign wr = PSEL_I & PENABLE_I & PWRITE_I;
	assign setup = PSEL_I & ~PENABLE_I;
	assign sel = PADDR_I[7:5];
	assign idx = PADDR_I[4:2];
	assign wsel = 2'(sel - 3'h1);
	assign is_global = (sel == `SEL_GLOBAL) && (PADDR_I[4] == 1'b0);
	assign is_wdt = (sel != `SEL_GLOBAL) && (sel <= `SEL_LAST_WDT);
	assign unmapped = (PADDR_I[1:0] != 2'h0) || !(is_global || is_wdt);
	assign cfg_wr = wr & is_wdt & ~unmapped;

	// ==========================================================
	// Write protection
	logic locked;

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
			locked <= 1'b1;
		else if (wr && !unmapped && PADDR_I == `OFS_PROTECT)
			locked <= (PWDATA_I != `WP_KEY);
	end

	// ==========================================================
	// Boot supervision
	logic [1:0] settle;
	logic boot_load;
	logic boot_armed;
	logic boot_done_wr;

	assign boot_load = (settle == `STRAP_SETTLE - 2'h1) && strap_s;
	assign boot_done_wr = wr && !unmapped && PADDR_I == `OFS_BOOT_CTRL
		&& PWDATA_I[`BOOT_DONE_BIT];

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			settle <= 2'h0;
			boot_armed <= 1'b0;
		end
		else
		begin
			if (settle != `STRAP_SETTLE)
				settle <= settle + 2'h1;
			if (boot_load)
				boot_armed <= 1'b1;
			else if (boot_done_wr)
				boot_armed <= 1'b0;
		end
	end

	// ==========================================================
	// Configuration and timeouts
	logic [`CFG_W-1:0] cfg [0:NWDT-1];
	logic [31:0] tmo [0:4*NWDT-1];
	logic [NWDT-1:0] feed;

	genvar g;
	generate
		for (g = 0; g < NWDT; g++)
		begin : g_cfg
			logic hit_w;
			logic is_boot_wdt;
			assign hit_w = cfg_wr && (wsel == 2'(g));
			assign is_boot_wdt = (g == 0) || (g == LP);
			assign feed[g] = hit_w && (idx == `IDX_FEED);

			always_ff @(posedge CLK_I or negedge rst_n)
			begin
				if (!rst_n)
					cfg[g] <= `CFG_RESET;
				else if (boot_load && is_boot_wdt)
					cfg[g] <= (g == LP) ? `CFG_BOOT_LP : `CFG_BOOT_MAIN;
				else if (boot_done_wr && boot_armed && is_boot_wdt)
					cfg[g][`CFG_EN_BIT] <= 1'b0;
				else if (hit_w && !locked && idx == `IDX_CONFIG)
					cfg[g] <= PWDATA_I[`CFG_W-1:0];
			end

			for (genvar s = 0; s < 4; s++)
			begin : g_tmo
				always_ff @(posedge CLK_I or negedge rst_n)
				begin
					if (!rst_n)
						tmo[4*g+s] <= `TIMEOUT_RESET;
					else if (boot_load && is_boot_wdt && s == 0)
						tmo[4*g+s] <= (g == LP) ? BOOT_TIMEOUT_LP : BOOT_TIMEOUT;
					else if (hit_w && !locked && idx == 3'(`IDX_TIMEOUT0 + s))
						tmo[4*g+s] <= PWDATA_I;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Watchdog engines
	logic [31:0] cnt [0:NWDT-1];
	logic [1:0] stg [0:NWDT-1];
	logic [1:0] estg [0:NWDT-1];
	logic [NWDT-1:0] expire;
	logic [NWDT-1:0] intr_set;
	scope_t req [0:NWDT];

	assign req[0] = 4'h0;

	generate
		for (g = 0; g < NWDT; g++)
		begin : g_wdt
			action_t act;
			assign act = action_t'(cfg[g][`CFG_ACT_LSB + 2*estg[g] +: 2]);

			wdt_stage_engine #(.STAGES(4), .CW(32)) u_engine
			(
				.clk_i(CLK_I),
				.rst_n_i(rst_n),
				// Sync flops leave reset low, so a high pin would fake an edge
				.tick_i((g == LP) ? (slow_tick && settle == `STRAP_SETTLE) : 1'b1),
				.enable_i(cfg[g][`CFG_EN_BIT]),
				.stage_en_i(cfg[g][`CFG_STG_EN_LSB +: 4]),
				.timeouts_i({tmo[4*g+3], tmo[4*g+2], tmo[4*g+1], tmo[4*g]}),
				.feed_i(feed[g]),
				.count_o(cnt[g]),
				.stage_o(stg[g]),
				.expire_o(expire[g]),
				.expire_stage_o(estg[g])
			);

			assign intr_set[g] = expire[g] && act == ACT_INTR;
			assign req[g+1] = req[g] | (expire[g] ?
				scope_of(act, g == LP, cfg[g][`CFG_CORE_BIT]) : 4'h0);
		end
	endgenerate

	// ==========================================================
	// Interrupt status and mask
	logic [NWDT-1:0] int_status;
	logic [NWDT-1:0] int_mask;
	logic [NWDT-1:0] w1c;

	assign w1c = (wr && !unmapped && PADDR_I == `OFS_INT_STATUS) ?
		PWDATA_I[NWDT-1:0] : '0;

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			int_status <= '0;
			int_mask <= '0;
			IRQ_O <= 1'b0;
		end
		else
		begin
			// Set beats a simultaneous clear
			int_status <= (int_status & ~w1c) | intr_set;
			if (wr && !unmapped && PADDR_I == `OFS_INT_MASK)
				int_mask <= PWDATA_I[NWDT-1:0];
			IRQ_O <= |(int_status & int_mask);
		end
	end

	// ==========================================================
	// Scoped reset requests
	logic [3:0] hold [0:3];
	logic [3:0] active;

	generate
		for (g = 0; g < 4; g++)
		begin : g_hold
			assign active[g] = hold[g] != 4'h0;
			always_ff @(posedge CLK_I or negedge rst_n)
			begin
				if (!rst_n)
					hold[g] <= 4'h0;
				else if (req[NWDT][g])
					hold[g] <= `RST_HOLD;
				else if (active[g])
					hold[g] <= hold[g] - 4'h1;
			end
		end
	endgenerate

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			FIRST_PROCESSOR_CORE_RST_O <= 1'b0;
			SECOND_PROCESSOR_CORE_RST_O <= 1'b0;
			SECURE_REGS_RST_O <= 1'b0;
			DIGITAL_CORE_RST_O <= 1'b0;
			SYSTEM_RST_O <= 1'b0;
		end
		else
		begin
			FIRST_PROCESSOR_CORE_RST_O <= active[0] | active[2] | active[3];
			SECOND_PROCESSOR_CORE_RST_O <= active[1] | active[2] | active[3];
			SECURE_REGS_RST_O <= active[0] | active[2] | active[3];
			DIGITAL_CORE_RST_O <= active[2] | active[3];
			SYSTEM_RST_O <= active[3];
		end
	end

	// ==========================================================
	// Read data, taken in the setup cycle so the access needs no wait
	logic [31:0] rd_global;
	logic [31:0] rd_wdt;
	logic [31:0] rd;

	assign rd_global =
		(PADDR_I == `OFS_PROTECT) ? {31'h0000_0000, locked} :
		(PADDR_I == `OFS_INT_STATUS) ? {29'h0000_0000, int_status} :
		(PADDR_I == `OFS_INT_MASK) ? {29'h0000_0000, int_mask} :
		{30'h0000_0000, strap_s, boot_armed};

	assign rd_wdt =
		(idx == `IDX_CONFIG) ? {18'h0_0000, cfg[wsel]} :
		(idx <= `IDX_TIMEOUT3) ? tmo[{wsel, 2'(idx - `IDX_TIMEOUT0)}] :
		(idx == `IDX_COUNT) ? cnt[wsel] :
		(idx == `IDX_STAGE) ? {30'h0000_0000, stg[wsel]} :
		32'h0000_0000;

	assign rd = unmapped ? 32'h0000_0000 : (is_global ? rd_global : rd_wdt);

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			PRDATA_O <= 32'h0000_0000;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
		else
		begin
			PREADY_O <= 1'b1;
			if (setup)
			begin
				PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd;
				PSLVERR_O <= unmapped;
			end
		end
	end

endmodule

`default_nettype wire

/* File: verilog/wdt_defines.svh */
// Purpose: Offsets, field positions, keys and counts of the watchdog unit
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ==========================================================
// Register map (byte addresses, one word each)
`define OFS_PROTECT 8'h00
`define OFS_INT_STATUS 8'h04
`define OFS_INT_MASK 8'h08
`define OFS_BOOT_CTRL 8'h0c
`define SEL_GLOBAL 3'h0
`define SEL_LAST_WDT 3'h3
`define IDX_CONFIG 3'h0
`define IDX_TIMEOUT0 3'h1
`define IDX_TIMEOUT3 3'h4
`define IDX_FEED 3'h5
`define IDX_COUNT 3'h6
`define IDX_STAGE 3'h7

// ==========================================================
// Config word layout
`define CFG_W 14
`define CFG_EN_BIT 0
`define CFG_STG_EN_LSB 1
`define CFG_ACT_LSB 5
`define CFG_CORE_BIT 13
`define CFG_RESET 14'h0000
// Boot supervision: stage 0 only; main resets the digital core, low-power the system
`define CFG_BOOT_MAIN 14'h0043
`define CFG_BOOT_LP 14'h0063

// ==========================================================
// Values and counts
`define WP_KEY 32'h1234_5678
`define TIMEOUT_RESET 32'h0000_ffff
`define RST_HOLD 4'hf
`define STRAP_SETTLE 2'h3
`define BOOT_DONE_BIT 0
`define SCOPE_CORE0 4'h1
`define SCOPE_CORE1 4'h2
`define SCOPE_DIGITAL 4'h4
`define SCOPE_SYSTEM 4'h8

`endif

/* File: verilog/wdt_pkg.sv */
// Purpose: Types and shared decoding of the watchdog unit
// Assumes: wdt_defines.svh available
// Notes: Scope bit 0 first core, 1 second core, 2 digital core, 3 system
`include "wdt_defines.svh"
`default_nettype none

package wdt_pkg;

	typedef enum logic [1:0]
	{
		ACT_INTR = 2'h0,
		ACT_CORE = 2'h1,
		ACT_DIGITAL = 2'h2,
		ACT_SYSTEM = 2'h3
	} action_t;

	typedef logic [3:0] scope_t;

	// Main watchdogs cannot reach the low-power domain
	function automatic scope_t scope_of(input action_t act, input logic is_lp, input logic core);
		scope_t s;
		s = 4'h0;
		unique case (act)
			ACT_INTR: s = 4'h0;
			ACT_CORE: s = core ? `SCOPE_CORE1 : `SCOPE_CORE0;
			ACT_DIGITAL: s = `SCOPE_DIGITAL;
			ACT_SYSTEM: s = is_lp ? `SCOPE_SYSTEM : `SCOPE_DIGITAL;
		endcase
		return s;
	endfunction

endpackage

`default_nettype wire

/* File: verilog/wdt_stage_engine.sv */
// Purpose: Four-stage watchdog counter
// Assumes: tick_i is a one-cycle count enable
// Notes: Feed or disable returns to stage 0 with a cleared count
`default_nettype none

module wdt_stage_engine #(
	parameter int STAGES = 4,
	parameter int CW = 32
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic enable_i,
	input wire logic [STAGES-1:0] stage_en_i,
	input wire logic [STAGES*CW-1:0] timeouts_i,
	input wire logic feed_i,
	output logic [CW-1:0] count_o,
	output logic [1:0] stage_o,
	output logic expire_o,
	output logic [1:0] expire_stage_o
);

	// ==========================================================
	// Datapath
	logic [CW-1:0] limit;
	logic [CW-1:0] next_count;
	logic hit;

	assign limit = timeouts_i[stage_o*CW +: CW];
	assign next_count = count_o + {{(CW-1){1'b0}}, 1'b1};
	assign hit = next_count >= limit;

	// ==========================================================
	// Stage sequencing
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count_o <= '0;
			stage_o <= 2'h0;
			expire_o <= 1'b0;
			expire_stage_o <= 2'h0;
		end
		else
		begin
			expire_o <= 1'b0;
			if (!enable_i || feed_i)
			begin
				count_o <= '0;
				stage_o <= 2'h0;
			end
			else if (!stage_en_i[stage_o])
			begin
				count_o <= '0;
				stage_o <= stage_o + 2'h1;
			end
			else if (tick_i)
			begin
				if (hit)
				begin
					expire_o <= 1'b1;
					expire_stage_o <= stage_o;
					count_o <= '0;
					stage_o <= stage_o + 2'h1;
				end
				else
					count_o <= next_count;
			end
		end
	end

endmodule

`default_nettype wire
